// File: hw/pms_defs.svh
// Constants for the serial management slave: offsets, fields, resets, frame lengths.
// Assumes inclusion by its bare name from the design and bench files.
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH
`define PMS_REG_INT_CTRL     5'h1b
`define PMS_REG_CTRL1        5'h16
`define PMS_REG_CTRL2        5'h1f
`define PMS_BCAST_OFF_BIT    9
`define PMS_INT_LEVEL_BIT    9
`define PMS_PREAMBLE_BITS    6'h20
`define PMS_START_CODE       2'h1
`define PMS_OP_READ          2'h2
`define PMS_OP_WRITE         2'h1
`define PMS_DATA_BITS        5'h10
`define PMS_CTRL1_RESET      16'h0000
`define PMS_CTRL2_RESET      16'h0000
`define PMS_INT_EN_RESET     8'h00
`define PMS_STALL_CYCLES     8'h18
`endif

// File: hw/pms_mgmt_slave.sv
// Serial management slave with interrupt register and interrupt pin.
// Assumes MDC and MDIO arrive asynchronously and core_clk is far faster than MDC.
`timescale 1ns/1ps
`include "pms_defs.svh"

// Behaviour
// - Answer own strapped address and broadcast address 0 by default.
// - Broadcast address 0 reads or writes; writes accepted by all devices.
// - Strap or control bit 9 of 16h turns address 0 into ordinary address.
// - Unit address taken from three straps sampled at reset release.
// - All registers 16 bits; 0 to 8 standard, higher ones vendor.
// - Frame opens with 32 ones, start 01, opcode 10 read or 01 write.
// - Address 00AAA, register, turnaround, 16 data bits; line idles released.
// - Interrupt register upper byte holds per-condition enables.
// - Interrupt register lower byte holds per-condition status flags.
// - Reading the interrupt register clears its status flags; flags set by events in the clearing cycle stay set.
// - Interrupt pin active low after reset; bit 9 of 1Fh selects high.
// - Enabled status update asserts the interrupt pin.
module pms_mgmt_slave (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Management link
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    // Straps
    input  wire logic [2:0]  unit_address_strap,
    input  wire logic        broadcast_disable_strap,
    // Interrupt sources and pin
    input  wire logic [7:0]  int_events,
    output logic             irq_out_pin,
    // Standard and vendor register data to and from the rest of the device
    input  wire logic [15:0] ext_rd_data,
    output logic [4:0]       ext_addr,
    output logic [15:0]      ext_wr_data,
    output logic             ext_wr_stb
);
    import pms_pkg::*;

    pms_st_t     s_reg;
    pms_st_t     s_next;
    logic        rise;
    logic        addr_hit;
    logic [15:0] rd_word;
    logic        wr_now;
    logic        clr_flags;
    logic [13:0] head_in;
    logic [1:0]  hdr_start;
    logic [1:0]  hdr_op;
    logic [4:0]  hdr_phy;
    logic [4:0]  hdr_reg;
    logic        own_hit;
    logic        bcast_hit;
    logic        op_ok;

    always_comb begin
        s_next    = s_reg;
        s_next.wr_stb = 1'b0;
        wr_now    = 1'b0;
        clr_flags = 1'b0;
        rd_word   = ext_rd_data;
        s_next.mdc_sync  = {s_reg.mdc_sync[0], mdc};
        s_next.mdio_sync = {s_reg.mdio_sync[0], mdio_in};
        s_next.mdc_prev  = s_reg.mdc_sync[1];
        rise = s_reg.mdc_sync[1] & ~s_reg.mdc_prev;
        // Header fields as they stand once this bit is in
        head_in   = {s_reg.head[12:0], s_reg.mdio_sync[1]};
        hdr_start = head_in[13:12];
        hdr_op    = head_in[11:10];
        hdr_phy   = head_in[9:5];
        hdr_reg   = head_in[4:0];
        own_hit   = (hdr_phy[4:3] == 2'h0) && (hdr_phy[2:0] == s_reg.unit_addr);
        bcast_hit = (hdr_phy == 5'h00) && !s_reg.bcast_strap &&
                    !s_reg.ctrl1[`PMS_BCAST_OFF_BIT];
        addr_hit  = own_hit || bcast_hit;
        op_ok     = (hdr_start == `PMS_START_CODE) &&
                    ((hdr_op == `PMS_OP_READ) || (hdr_op == `PMS_OP_WRITE));
        // Straps pass two flops, then stay frozen
        s_next.strap_sync = unit_address_strap;
        s_next.bcast_sync = broadcast_disable_strap;
        if (!s_reg.rst_seen) begin
            s_next.strap_wait  = s_reg.strap_wait + 2'h1;
            s_next.unit_addr   = s_reg.strap_sync;
            s_next.bcast_strap = s_reg.bcast_sync;
            if (s_reg.strap_wait == 2'h1) begin
                s_next.rst_seen = 1'b1;
            end
        end
        // Register read mux
        unique case (s_reg.reg_addr)
            `PMS_REG_INT_CTRL: rd_word = {s_reg.int_en, s_reg.int_flags};
            `PMS_REG_CTRL1:    rd_word = s_reg.ctrl1;
            `PMS_REG_CTRL2:    rd_word = s_reg.ctrl2;
            default:           rd_word = ext_rd_data;
        endcase
        if (rise) begin
            unique case (s_reg.state)
                PMS_IDLE: begin
                    if (s_reg.mdio_sync[1]) begin
                        if (s_reg.ones_cnt != `PMS_PREAMBLE_BITS) begin
                            s_next.ones_cnt = s_reg.ones_cnt + 6'h01;
                        end
                    end else begin
                        if (s_reg.ones_cnt == `PMS_PREAMBLE_BITS) begin
                            s_next.state   = PMS_HEAD;
                            s_next.bit_cnt = 5'h01;
                            s_next.head    = 14'h0000;
                        end
                        s_next.ones_cnt = 6'h00;
                    end
                end
                PMS_HEAD: begin
                    s_next.head    = {s_reg.head[12:0], s_reg.mdio_sync[1]};
                    s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                    if (s_reg.bit_cnt == 5'h0d) begin
                        s_next.reg_addr = hdr_reg;
                        s_next.is_read  = (hdr_op == `PMS_OP_READ);
                        s_next.bit_cnt  = 5'h00;
                        if (!op_ok) begin
                            s_next.state = PMS_IDLE;
                        end else if (addr_hit) begin
                            s_next.state = PMS_TA;
                        end else begin
                            s_next.state = PMS_SKIP;
                        end
                    end
                end
                PMS_TA: begin
                    s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                    if (s_reg.bit_cnt == 5'h00 && s_reg.is_read) begin
                        s_next.mdio_oe_n = 1'b0;
                        s_next.mdio_out  = 1'b0;
                        s_next.shift     = rd_word;
                        if (s_reg.reg_addr == `PMS_REG_INT_CTRL) begin
                            clr_flags = 1'b1;
                        end
                    end
                    if (s_reg.bit_cnt == 5'h01) begin
                        s_next.state   = PMS_DATA;
                        s_next.bit_cnt = 5'h00;
                        if (s_reg.is_read) begin
                            s_next.mdio_out = s_reg.shift[15];
                            s_next.shift    = {s_reg.shift[14:0], 1'b0};
                        end
                    end
                end
                PMS_DATA: begin
                    s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                    if (s_reg.is_read) begin
                        s_next.mdio_out = s_reg.shift[15];
                        s_next.shift    = {s_reg.shift[14:0], 1'b0};
                    end else begin
                        s_next.shift = {s_reg.shift[14:0], s_reg.mdio_sync[1]};
                    end
                    if (s_reg.bit_cnt == `PMS_DATA_BITS - 5'h01) begin
                        s_next.state     = PMS_IDLE;
                        s_next.ones_cnt  = 6'h00;
                        s_next.mdio_oe_n = 1'b1;
                        s_next.mdio_out  = 1'b0;
                        wr_now           = !s_reg.is_read;
                    end
                end
                PMS_SKIP: begin
                    s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                    if (s_reg.bit_cnt == `PMS_DATA_BITS + 5'h01) begin
                        s_next.state    = PMS_IDLE;
                        s_next.ones_cnt = 6'h00;
                    end
                end
                default: begin
                    s_next.state = PMS_IDLE;
                end
            endcase
        end
        if (wr_now) begin
            unique case (s_reg.reg_addr)
                `PMS_REG_INT_CTRL: s_next.int_en = s_next.shift[15:8];
                `PMS_REG_CTRL1:    s_next.ctrl1  = s_next.shift;
                `PMS_REG_CTRL2:    s_next.ctrl2  = s_next.shift;
                default:           s_next.wr_stb = 1'b1;
            endcase
        end
        // Abandon a frame whose clock has stopped; slow clocks must keep rise-to-rise periods short
        if (rise || s_reg.state == PMS_IDLE) begin
            s_next.stall_cnt = 8'h00;
        end else if (s_reg.stall_cnt == `PMS_STALL_CYCLES) begin
            s_next.state     = PMS_IDLE;
            s_next.ones_cnt  = 6'h00;
            s_next.mdio_oe_n = 1'b1;
            s_next.mdio_out  = 1'b0;
            s_next.stall_cnt = 8'h00;
        end else begin
            s_next.stall_cnt = s_reg.stall_cnt + 8'h01;
        end
        // Event sets win over the read clear
        s_next.int_flags = (clr_flags ? 8'h00 : s_reg.int_flags) | int_events;
        s_next.irq_level = |(s_next.int_flags & s_next.int_en);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '{state: PMS_IDLE, mdio_oe_n: 1'b1, ctrl1: `PMS_CTRL1_RESET,
                       ctrl2: `PMS_CTRL2_RESET, int_en: `PMS_INT_EN_RESET, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        mdio_out    = s_reg.mdio_out;
        mdio_oe_n   = s_reg.mdio_oe_n;
        irq_out_pin = s_reg.irq_level ~^ s_reg.ctrl2[`PMS_INT_LEVEL_BIT];
        ext_addr    = s_reg.reg_addr;
        ext_wr_data = s_reg.shift;
        ext_wr_stb  = s_reg.wr_stb;
    end
endmodule

// File: hw/pms_pkg.sv
// Types for the serial management slave.
// Assumes the constants header sits beside it.
package pms_pkg;
    typedef enum logic [2:0] {
        PMS_IDLE = 3'b000,
        PMS_HEAD = 3'b001,
        PMS_TA   = 3'b010,
        PMS_DATA = 3'b011,
        PMS_SKIP = 3'b100
    } pms_state_t;

    typedef struct packed {
        logic [1:0]  mdc_sync;
        logic [1:0]  mdio_sync;
        logic        mdc_prev;
        logic        rst_seen;
        logic [2:0]  unit_addr;
        logic        bcast_strap;
        pms_state_t  state;
        logic [5:0]  ones_cnt;
        logic [4:0]  bit_cnt;
        logic [13:0] head;
        logic [15:0] shift;
        logic        is_read;
        logic [4:0]  reg_addr;
        logic        mdio_oe_n;
        logic        mdio_out;
        logic [15:0] ctrl1;
        logic [15:0] ctrl2;
        logic [7:0]  int_en;
        logic [7:0]  int_flags;
        logic        irq_level;
        logic [2:0]  strap_sync;
        logic        bcast_sync;
        logic [1:0]  strap_wait;
        logic        wr_stb;
        logic [7:0]  stall_cnt;
    } pms_st_t;
endpackage

// File: verification/phy_mgmt_serial_irq_tb_top.sv
// Bench for the management slave: random reads, interrupts, broadcast.
// Assumes the controller model and the pull-up on the data line.
`timescale 1ns/1ps
`include "pms_defs.svh"
module phy_mgmt_serial_irq_tb_top;
    logic        core_clk = 1'b0, arst_n = 1'b0, bcast_off = 1'b0;
    logic        mdc, drv_en, drv_bit, mdio_out, mdio_oe_n, irq_out_pin, ext_wr_stb;
    logic [2:0]  strap = 3'h0, own;
    logic [4:0]  me, ext_addr;
    logic [7:0]  ev = 8'h00, en, e;
    logic [15:0] ext_rd = 16'h0000, ext_wr_data, rdv;
    int          miscompares = 0, checks = 0;
    logic [4:0]  stb_addr = 5'h00;
    logic [15:0] stb_data = 16'h0000;
    int          stb_cnt = 0;
    always @(posedge core_clk) begin
        if (ext_wr_stb) begin
            stb_cnt  <= stb_cnt + 1;
            stb_addr <= ext_addr;
            stb_data <= ext_wr_data;
        end
    end
    wire logic   mdio = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);
    always #12.5 core_clk = ~core_clk;
    pms_mac_model mac (.mdc(mdc), .drv_en(drv_en), .drv_bit(drv_bit), .mdio(mdio));
    pms_mgmt_slave uut (.core_clk(core_clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .unit_address_strap(strap),
        .broadcast_disable_strap(bcast_off), .int_events(ev), .irq_out_pin(irq_out_pin),
        .ext_rd_data(ext_rd), .ext_addr(ext_addr), .ext_wr_data(ext_wr_data),
        .ext_wr_stb(ext_wr_stb));
    function automatic logic [15:0] irq_exp(input logic [7:0] n, f, input logic hi);
        return 16'(hi == |(n & f));
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic pulse(input logic [7:0] p);
        idle(1);
        ev = p;
        idle(1);
        ev = 8'h00;
        idle(4);
    endtask
    task automatic rd(input logic [4:0] pa, ra);
        mac.frame(`PMS_OP_READ, pa, ra, 16'h0000, rdv);
    endtask
    task automatic wr(input logic [4:0] pa, ra, input logic [15:0] wd);
        mac.frame(`PMS_OP_WRITE, pa, ra, wd, rdv);
    endtask
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(57239));
        own = 3'($urandom_range(6, 1));
        me = {2'h0, own};
        strap = own;
        idle(2);
        arst_n = 1'b1;
        idle(1);
        strap = ~own;
        chk("irq after reset", 16'h0001, 16'(irq_out_pin));
        for (int k = 0; k < 4; k++) begin
            ext_rd = 16'($urandom);
            rd(k[0] ? 5'h00 : me, 5'($urandom_range(8, 0)));
            chk("read data", ext_rd, rdv);
        end
        rd({2'h0, ~own}, 5'h02);
        chk("foreign read", 16'hffff, rdv);
        rd({2'h1, own}, 5'h02);
        chk("upper address read", 16'hffff, rdv);
        ext_rd = 16'($urandom);
        wr(me, 5'h04, ext_rd);
        chk("ext write count", 16'h0001, 16'(stb_cnt));
        chk("ext write addr", 16'h0004, 16'(stb_addr));
        chk("ext write data", ext_rd, stb_data);
        en = {1'b0, 7'($urandom)} | 8'h01;
        e = 8'($urandom) | 8'h01;
        wr(5'h00, `PMS_REG_INT_CTRL, {en, 8'h00});
        pulse(~en);
        chk("masked irq", 16'h0001, 16'(irq_out_pin));
        rd(me, `PMS_REG_INT_CTRL);
        chk("flags masked", {en, ~en}, rdv);
        pulse(e);
        chk("irq low level", irq_exp(en, e, 1'b0), 16'(irq_out_pin));
        rd(me, `PMS_REG_INT_CTRL);
        chk("flags", {en, e}, rdv);
        chk("irq after clear", 16'h0001, 16'(irq_out_pin));
        rd(me, `PMS_REG_INT_CTRL);
        chk("flags cleared", {en, 8'h00}, rdv);
        wr(me, `PMS_REG_CTRL2, 16'h0001 << `PMS_INT_LEVEL_BIT);
        idle(8);
        chk("irq high idle", 16'h0000, 16'(irq_out_pin));
        pulse(e);
        chk("irq high level", irq_exp(en, e, 1'b1), 16'(irq_out_pin));
        wr(me, `PMS_REG_CTRL1, 16'h0001 << `PMS_BCAST_OFF_BIT);
        rd(5'h00, `PMS_REG_INT_CTRL);
        chk("broadcast off", 16'hffff, rdv);
        rd(me, `PMS_REG_INT_CTRL);
        chk("flags kept", {en, e}, rdv);
        chk("ext write total", 16'h0001, 16'(stb_cnt));
        end_sim();
    end
endmodule

// File: verification/pms_mac_model.sv
// Station controller model: makes the management clock and frames.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
`include "pms_defs.svh"
module pms_mac_model (
    // Management link
    output logic      mdc,
    output logic      drv_en,
    output logic      drv_bit,
    input  wire logic mdio
);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
    end
    // One bit: change while clock low, sample at the rise
    task automatic bit_cyc(input logic en, input logic b, output logic s);
        drv_en = en;
        drv_bit = b;
        #100;
        mdc = 1'b1;
        s = mdio;
        #100;
        mdc = 1'b0;
    endtask
    // Whole frame; the clock stands low afterwards
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hffffffff, `PMS_START_CODE, op, pa, ra};
        for (int i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
        bit_cyc(op != `PMS_OP_READ, 1'b1, s);
        bit_cyc(op != `PMS_OP_READ, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cyc(op != `PMS_OP_READ, wd[i], s);
            rd[i] = s;
        end
        drv_en = 1'b0;
    endtask
endmodule

// File: verification/pms_mgmt_slave_chk.sv
// Timing checks on the management slave pins.
// Assumes bind to the slave and a free-running core clock.
`timescale 1ns/1ps
module pms_mgmt_slave_chk (
    // Clock, link and interrupt
    input wire logic       core_clk, arst_n, mdc,
    input wire logic       mdio_out, mdio_oe_n, irq_out_pin,
    input wire logic [7:0] int_events
);
    logic       mdc_q;
    logic [7:0] since_rise, low_cnt;
    logic [3:0] ev_age;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mdc_q <= 1'b0;
            since_rise <= 8'hff;
            low_cnt <= 8'h00;
            ev_age <= 4'hf;
        end else begin
            mdc_q <= mdc;
            since_rise <= (mdc && !mdc_q) ? 8'h00 : since_rise + 8'(since_rise != 8'hff);
            low_cnt <= mdio_oe_n ? 8'h00 : low_cnt + 8'h01;
            ev_age <= (|int_events) ? 4'h0 : ev_age + 4'(ev_age != 4'hf);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_oe_after_rise: assert property ($changed(mdio_oe_n) |-> since_rise <= 8'h06)
        else $error("line enable moved away from a clock rise");
    a_bit_after_rise: assert property (!mdio_oe_n && $changed(mdio_out) |-> since_rise <= 8'h06)
        else $error("driven bit moved away from a clock rise");
    a_ta_bit_zero: assert property ($fell(mdio_oe_n) |-> !mdio_out)
        else $error("first driven bit is not zero");
    a_drive_bounded: assert property (low_cnt < 8'h96)
        else $error("line driven too long");
    a_idle_released: assert property (since_rise > 8'h28 |-> mdio_oe_n)
        else $error("line driven while clock stands");
    a_oe_reset_high: assert property ($rose(arst_n) |-> mdio_oe_n)
        else $error("line driven after reset");
    a_irq_reset_high: assert property ($rose(arst_n) |-> irq_out_pin)
        else $error("interrupt pin active after reset");
    a_irq_has_cause: assert property ($changed(irq_out_pin) |-> ev_age <= 4'h3 || since_rise <= 8'h08)
        else $error("interrupt pin moved without cause");
    c_read_drive: cover property ($fell(mdio_oe_n));
    c_irq_move: cover property ($changed(irq_out_pin));
    c_long_idle: cover property (since_rise == 8'hff);
endmodule
bind pms_mgmt_slave pms_mgmt_slave_chk u_chk (.core_clk(core_clk), .arst_n(arst_n), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .irq_out_pin(irq_out_pin), .int_events(int_events));
